// file: include/memctl_defines.svh
`ifndef MEMCTL_DEFINES_SVH
`define MEMCTL_DEFINES_SVH
// Behaviour
// - SDRAM row/col line is address bit on row, command bit on column.
// - Six programmable lines follow the loaded pattern word by word.
// - SDRAM write enable drives the SDRAM write-enable input directly.
// - Separate row and column strobes go to the SDRAM strobe inputs.
// - Chip-select machine asserts output enable during reads.
// - External acknowledge ends a chip-select machine access.
// - Wait input high stalls the programmable machine pattern.
// - Parity byte select enables the separate parity chip during accesses.
// - In external-master mode, address mux control switches row/column phase.
// - Eight chip selects, one per attached device.
// - Eight byte-lane write enables during chip-select machine writes.
// - Eight SDRAM byte masks select SDRAM byte lanes.

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MC_CLK_PERIOD_NS 5
`define MC_TRCD_NS       15
`define MC_TRCD_CYC      ((`MC_TRCD_NS + `MC_CLK_PERIOD_NS - 1) / `MC_CLK_PERIOD_NS)
`define MC_ACK_TIMEOUT   255

// ----------------------------------------------------------------------
// Widths and idle levels
// ----------------------------------------------------------------------
`define MC_ADDR_W        13
`define MC_A10_BIT       10
`define MC_LANES         8
`define MC_GPL_W         6
`define MC_PAT_AW        6
`define MC_GPL_IDLE      6'h3f
`define MC_CS_IDLE       8'hff
`define MC_BWE_IDLE      8'hff
`define MC_DQM_IDLE      8'hff
`endif

// file: include/memctl_pkg.sv
package memctl_pkg;
  `include "memctl_defines.svh"

  typedef enum logic [1:0] {
    MACH_SDRAM = 2'h0,
    MACH_GENERAL_CHIP_SELECT_MACHINE  = 2'h1,
    MACH_UPM   = 2'h2
  } mach_t;

  typedef struct packed {
    mach_t                   mach;
    logic                    write;
    logic                    auto_pre;
    logic                    parity_en;
    logic                    ext_master;
    logic [2:0]              cs;
    logic [`MC_LANES-1:0]    be;
    logic [`MC_ADDR_W-1:0]   row;
    logic [`MC_ADDR_W-1:0]   col;
    logic [`MC_PAT_AW-1:0]   upm_start;
  } req_t;

  typedef struct packed {
    logic [`MC_GPL_W-1:0]    gpl;
    logic                    cs_on;
    logic                    bs_on;
    logic                    last;
  } pat_word_t;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_SD_ACT = 7'h02,
    ST_SD_RCD = 7'h04,
    ST_SD_CMD = 7'h08,
    ST_GP_RUN = 7'h10,
    ST_UP_RUN = 7'h20,
    ST_FINISH = 7'h40
  } state_t;
endpackage

// file: design/upm_engine.sv
`timescale 1ns/100ps
`include "memctl_defines.svh"
module upm_engine
  import memctl_pkg::*;
#(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Pattern load
  input  wire logic                  pat_we_i,
  input  wire logic [`MC_PAT_AW-1:0] pat_addr_i,
  input  wire pat_word_t             pat_data_i,
  // Run control
  input  wire logic                  start_i,
  input  wire logic [`MC_PAT_AW-1:0] start_addr_i,
  input  wire logic                  wait_i,
  output      logic                  busy_o,
  output      logic                  done_o,
  output      pat_word_t             word_o
);
  pat_word_t             pat_mem [DEPTH];
  logic [`MC_PAT_AW-1:0] ptr_ff;
  logic                  busy_ff;
  logic                  done_ff;
  wire                   step = busy_ff && !wait_i;

  assign word_o = pat_mem[ptr_ff];
  assign busy_o = busy_ff;
  assign done_o = done_ff;

  // Pattern memory has no reset; software reloads it before use
  always_ff @(posedge clk_i) begin
    if (pat_we_i) begin
      pat_mem[pat_addr_i] <= pat_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= step && word_o.last;
      if (start_i && !busy_ff) begin
        ptr_ff  <= start_addr_i;
        busy_ff <= 1'b1;
      end else if (step) begin
        if (word_o.last) begin
          busy_ff <= 1'b0;
        end else begin
          ptr_ff <= ptr_ff + 1'b1;
        end
      end
    end
  end
endmodule

// file: design/memctl_pins.sv
`timescale 1ns/100ps
`include "memctl_defines.svh"
module memctl_pins
  import memctl_pkg::*;
#(
  parameter int PAT_DEPTH   = 64,
  parameter int ACK_TIMEOUT = `MC_ACK_TIMEOUT
) (
  // Clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  RST_I,
  // Transaction request
  input  wire logic                  REQ_VALID_I,
  input  wire req_t                  REQ_I,
  output      logic                  REQ_READY_O,
  output      logic                  DONE_O,
  output      logic                  TIMEOUT_O,
  // Programmable machine pattern load
  input  wire logic                  PAT_WE_I,
  input  wire logic [`MC_PAT_AW-1:0] PAT_ADDR_I,
  input  wire pat_word_t             PAT_DATA_I,
  // External inputs
  input  wire logic                  CHIP_SELECT_MACHINE_ACK_IN_N_I,
  input  wire logic                  PROG_MACHINE_WAIT_IN_I,
  // Chip-select machine pins
  output      logic [`MC_LANES-1:0]  CS_N_O,
  output      logic [`MC_LANES-1:0]  BYTE_WRITE_ENABLE_N_O,
  output      logic                  MEMORY_OUTPUT_ENABLE_N_O,
  output      logic                  PARITY_BYTE_SELECT_N_O,
  // SDRAM machine pins
  output      logic [`MC_ADDR_W-1:0] SDRAM_ADDR_O,
  output      logic                  SDRAM_ROW_COL_LINE_O,
  output      logic                  SDRAM_WRITE_ENABLE_N_O,
  output      logic                  SDRAM_ROW_STROBE_N_O,
  output      logic                  SDRAM_COLUMN_STROBE_N_O,
  output      logic [`MC_LANES-1:0]  SDRAM_BYTE_MASK_O,
  output      logic                  SDRAM_ADDR_MUX_CTRL_O,
  // Programmable machine pins
  output      logic [`MC_GPL_W-1:0]  PROG_MACHINE_GENERAL_LINE_O
);
  localparam logic [15:0] TRCD_CYC = 16'(`MC_TRCD_CYC);
  localparam logic [15:0] ACK_LIM  = 16'(ACK_TIMEOUT);

  // ----------------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------------
  // A change is taken only once stages two and three agree, to reject glitches
  logic [2:0] ack_sync_ff;
  logic [2:0] wait_sync_ff;
  logic       ack_n_ff;
  logic       ack_n_dly_ff;
  logic       wait_ff;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ack_sync_ff  <= 3'h7;
      wait_sync_ff <= 3'h0;
      ack_n_ff     <= 1'b1;
      ack_n_dly_ff <= 1'b1;
      wait_ff      <= 1'b0;
    end else begin
      ack_sync_ff  <= {ack_sync_ff[1:0], CHIP_SELECT_MACHINE_ACK_IN_N_I};
      wait_sync_ff <= {wait_sync_ff[1:0], PROG_MACHINE_WAIT_IN_I};
      ack_n_dly_ff <= ack_n_ff;
      if (ack_sync_ff[1] == ack_sync_ff[2]) begin
        ack_n_ff <= ack_sync_ff[2];
      end
      if (wait_sync_ff[1] == wait_sync_ff[2]) begin
        wait_ff <= wait_sync_ff[2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Programmable machine
  // ----------------------------------------------------------------------
  state_t    state_ff;
  state_t    nxt_state;
  req_t      req_ff;
  logic      upm_busy;
  logic      upm_done;
  pat_word_t upm_word;
  wire       accept    = (state_ff == ST_IDLE) && REQ_VALID_I;
  wire       upm_start = accept && (REQ_I.mach == MACH_UPM);

  upm_engine #(
    .DEPTH (PAT_DEPTH)
  ) u_upm (
    .clk_i        (CLK_I),
    .rst_i        (RST_I),
    .pat_we_i     (PAT_WE_I),
    .pat_addr_i   (PAT_ADDR_I),
    .pat_data_i   (PAT_DATA_I),
    .start_i      (upm_start),
    .start_addr_i (REQ_I.upm_start),
    .wait_i       (wait_ff),
    .busy_o       (upm_busy),
    .done_o       (upm_done),
    .word_o       (upm_word)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  logic [15:0] cnt_ff;
  logic        timeout_ff;
  wire         rcd_done = (cnt_ff >= TRCD_CYC - 16'h0001);
  // Only a fresh falling acknowledge counts: the filtered level of the last
  // access releases late and must not end the next access at once
  wire         ack_seen = ack_n_dly_ff && !ack_n_ff;
  wire         ack_late = (cnt_ff >= ACK_LIM);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (REQ_VALID_I) begin
          case (REQ_I.mach)
            MACH_SDRAM: nxt_state = ST_SD_ACT;
            MACH_GENERAL_CHIP_SELECT_MACHINE:  nxt_state = ST_GP_RUN;
            MACH_UPM:   nxt_state = ST_UP_RUN;
            default:    nxt_state = ST_IDLE;
          endcase
        end
      end
      ST_SD_ACT: nxt_state = (TRCD_CYC > 16'h0001) ? ST_SD_RCD : ST_SD_CMD;
      ST_SD_RCD: begin
        if (rcd_done) begin
          nxt_state = ST_SD_CMD;
        end
      end
      ST_SD_CMD: nxt_state = ST_FINISH;
      ST_GP_RUN: begin
        if (ack_seen || ack_late) begin
          nxt_state = ST_FINISH;
        end
      end
      ST_UP_RUN: begin
        if (upm_done) begin
          nxt_state = ST_FINISH;
        end
      end
      ST_FINISH: nxt_state = ST_IDLE;
      default:   nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_ff   <= ST_IDLE;
      req_ff     <= '0;
      cnt_ff     <= '0;
      timeout_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      timeout_ff <= (state_ff == ST_GP_RUN) && !ack_seen && ack_late;
      if (accept) begin
        req_ff <= REQ_I;
      end
      if (nxt_state != state_ff) begin
        cnt_ff <= '0;
      end else if (cnt_ff != 16'hffff) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------------
  wire in_act = (state_ff == ST_SD_ACT);
  wire in_rcd = (state_ff == ST_SD_RCD);
  wire in_cmd = (state_ff == ST_SD_CMD);
  wire in_sd  = in_act || in_rcd || in_cmd;
  wire in_gp  = (state_ff == ST_GP_RUN) && !ack_seen;
  wire in_up  = (state_ff == ST_UP_RUN) && upm_busy;
  wire cs_on  = in_sd || in_gp || (in_up && upm_word.cs_on);

  wire [`MC_LANES-1:0] nxt_cs_n  = cs_on ? ~(8'h01 << req_ff.cs) : `MC_CS_IDLE;
  wire [`MC_LANES-1:0] nxt_bwe_n = (in_gp && req_ff.write) ? ~req_ff.be : `MC_BWE_IDLE;
  wire                 nxt_oe_n  = !(in_gp && !req_ff.write);
  wire                 nxt_pbs_n = !(req_ff.parity_en &&
                                     (in_cmd || in_gp || (in_up && upm_word.bs_on)));
  wire                 nxt_a10   = in_act ? req_ff.row[`MC_A10_BIT] :
                                   (in_cmd && req_ff.auto_pre);
  wire [`MC_ADDR_W-1:0] col_addr = {req_ff.col[`MC_ADDR_W-1:`MC_A10_BIT+1], 1'b0,
                                    req_ff.col[`MC_A10_BIT-1:0]};
  wire [`MC_ADDR_W-1:0] nxt_addr = in_act ? req_ff.row : (in_cmd ? col_addr : '0);
  wire                 nxt_we_n  = !(in_cmd && req_ff.write);
  wire                 nxt_ras_n = !in_act;
  wire                 nxt_cas_n = !in_cmd;
  wire [`MC_LANES-1:0] nxt_dqm   = in_cmd ? (req_ff.write ? ~req_ff.be : 8'h00)
                                          : `MC_DQM_IDLE;
  wire                 nxt_amux  = req_ff.ext_master && (in_rcd || in_cmd);
  wire [`MC_GPL_W-1:0] nxt_gpl   = in_up ? upm_word.gpl : `MC_GPL_IDLE;

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  // Every pin comes from a flop; pins trail the sequencer state by a cycle, except REQ_READY_O, which is taken from the next state
  // Idle levels at reset
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      REQ_READY_O                 <= 1'b0;
      DONE_O                      <= 1'b0;
      TIMEOUT_O                   <= 1'b0;
      CS_N_O                      <= `MC_CS_IDLE;
      BYTE_WRITE_ENABLE_N_O       <= `MC_BWE_IDLE;
      MEMORY_OUTPUT_ENABLE_N_O    <= 1'b1;
      PARITY_BYTE_SELECT_N_O      <= 1'b1;
      SDRAM_ADDR_O                <= '0;
      SDRAM_ROW_COL_LINE_O        <= 1'b0;
      SDRAM_WRITE_ENABLE_N_O      <= 1'b1;
      SDRAM_ROW_STROBE_N_O        <= 1'b1;
      SDRAM_COLUMN_STROBE_N_O     <= 1'b1;
      SDRAM_BYTE_MASK_O           <= `MC_DQM_IDLE;
      SDRAM_ADDR_MUX_CTRL_O       <= 1'b0;
      PROG_MACHINE_GENERAL_LINE_O <= `MC_GPL_IDLE;
    end else begin
      REQ_READY_O                 <= (nxt_state == ST_IDLE);
      DONE_O                      <= (state_ff == ST_FINISH);
      TIMEOUT_O                   <= timeout_ff;
      CS_N_O                      <= nxt_cs_n;
      BYTE_WRITE_ENABLE_N_O       <= nxt_bwe_n;
      MEMORY_OUTPUT_ENABLE_N_O    <= nxt_oe_n;
      PARITY_BYTE_SELECT_N_O      <= nxt_pbs_n;
      SDRAM_ADDR_O                <= nxt_addr;
      SDRAM_ROW_COL_LINE_O        <= nxt_a10;
      SDRAM_WRITE_ENABLE_N_O      <= nxt_we_n;
      SDRAM_ROW_STROBE_N_O        <= nxt_ras_n;
      SDRAM_COLUMN_STROBE_N_O     <= nxt_cas_n;
      SDRAM_BYTE_MASK_O           <= nxt_dqm;
      SDRAM_ADDR_MUX_CTRL_O       <= nxt_amux;
      PROG_MACHINE_GENERAL_LINE_O <= nxt_gpl;
    end
  end
endmodule

// file: dv/mem_far_side.sv
`timescale 1ns/100ps
module mem_far_side (
  // Pins from the controller
  input  wire logic       clk_i,
  input  wire logic [7:0] cs_n_i,
  input  wire logic       oe_n_i,
  input  wire logic [7:0] bwe_n_i,
  // Scenario control
  input  wire logic       ack_en_i,
  input  wire logic [7:0] ack_dly_i,
  // Acknowledge pin
  output      logic       ack_n_o
);
  int  cnt = 0;
  wire access = (cs_n_i != 8'hff) && (!oe_n_i || bwe_n_i != 8'hff);

  // ----------
  // Acknowledge
  // ----------
  // Ack ends access
  // Pulled-up line, so a released acknowledge reads high
  initial ack_n_o = 1'b1;
  always @(posedge clk_i) begin
    #1;
    cnt = access ? cnt + 1 : 0;
    ack_n_o = !(ack_en_i && access && cnt > ack_dly_i);
  end
endmodule

// file: dv/memctl_pins_checker.sv
`timescale 1ns/100ps
module memctl_pins_checker (
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_I,
  // Watched pins
  input wire logic        DONE_O,
  input wire logic        CHIP_SELECT_MACHINE_ACK_IN_N_I,
  input wire logic        PROG_MACHINE_WAIT_IN_I,
  input wire logic [7:0]  CS_N_O,
  input wire logic [7:0]  BYTE_WRITE_ENABLE_N_O,
  input wire logic        MEMORY_OUTPUT_ENABLE_N_O,
  input wire logic        PARITY_BYTE_SELECT_N_O,
  input wire logic [12:0] SDRAM_ADDR_O,
  input wire logic        SDRAM_ROW_COL_LINE_O,
  input wire logic        SDRAM_WRITE_ENABLE_N_O,
  input wire logic        SDRAM_ROW_STROBE_N_O,
  input wire logic        SDRAM_COLUMN_STROBE_N_O,
  input wire logic [7:0]  SDRAM_BYTE_MASK_O,
  input wire logic        SDRAM_ADDR_MUX_CTRL_O,
  input wire logic [5:0]  PROG_MACHINE_GENERAL_LINE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire cs_on = CS_N_O != 8'hff;

  a_reset_idle_pins:
  assert property ($fell(RST_I) |-> !cs_on && SDRAM_ROW_STROBE_N_O && SDRAM_COLUMN_STROBE_N_O
    && MEMORY_OUTPUT_ENABLE_N_O && PROG_MACHINE_GENERAL_LINE_O == 6'h3f)
    else $error("pins active after reset");
  a_row_a10_bit:
  assert property (!SDRAM_ROW_STROBE_N_O |-> SDRAM_ROW_COL_LINE_O == SDRAM_ADDR_O[10])
    else $error("row line differs from row bit");
  a_col_addr_bit:
  assert property (!SDRAM_COLUMN_STROBE_N_O |-> !SDRAM_ADDR_O[10])
    else $error("column address bit ten set");
  a_ras_to_cas:
  assert property ($fell(SDRAM_ROW_STROBE_N_O) |-> ##[3:5] !SDRAM_COLUMN_STROBE_N_O)
    else $error("no column strobe after row strobe");
  a_we_with_cas:
  assert property (!SDRAM_WRITE_ENABLE_N_O |-> !SDRAM_COLUMN_STROBE_N_O && SDRAM_ROW_STROBE_N_O)
    else $error("write enable outside column command");
  a_mask_idle_level:
  assert property (SDRAM_COLUMN_STROBE_N_O |-> SDRAM_BYTE_MASK_O == 8'hff)
    else $error("byte mask active outside command");
  a_mux_col_phase:
  assert property (SDRAM_ADDR_MUX_CTRL_O |-> SDRAM_ROW_STROBE_N_O)
    else $error("mux in column phase during row strobe");
  a_oe_read_only:
  assert property (!MEMORY_OUTPUT_ENABLE_N_O |-> cs_on && BYTE_WRITE_ENABLE_N_O == 8'hff)
    else $error("output enable without read");
  a_cs_one_hot:
  assert property (cs_on |-> $onehot(~CS_N_O))
    else $error("more than one chip select");
  a_lane_write_cs:
  assert property (BYTE_WRITE_ENABLE_N_O != 8'hff |-> cs_on && MEMORY_OUTPUT_ENABLE_N_O)
    else $error("lane write without selected write");
  a_parity_with_cs:
  assert property (!PARITY_BYTE_SELECT_N_O |-> cs_on)
    else $error("parity select without access");
  a_ack_ends_access:
  assert property ($fell(CHIP_SELECT_MACHINE_ACK_IN_N_I) && (!MEMORY_OUTPUT_ENABLE_N_O
    || BYTE_WRITE_ENABLE_N_O != 8'hff) |-> ##[2:10] DONE_O)
    else $error("acknowledge did not end access");
  a_wait_holds_lines:
  assert property (PROG_MACHINE_WAIT_IN_I [*7] |-> $stable(PROG_MACHINE_GENERAL_LINE_O))
    else $error("lines moved while waiting");

  c_sdram_write: cover property (!SDRAM_COLUMN_STROBE_N_O && !SDRAM_WRITE_ENABLE_N_O);
  c_read_done: cover property (!MEMORY_OUTPUT_ENABLE_N_O ##[1:10] DONE_O);
  c_long_wait: cover property (PROG_MACHINE_WAIT_IN_I [*8]);
endmodule

bind memctl_pins memctl_pins_checker chk (.*);

// file: dv/memctl_pins_test.sv
`timescale 1ns/100ps
module memctl_pins_test;
  import memctl_pkg::*;
  // ----------
  // Signals
  // ----------
  logic        CLK_I = 1'b0, RST_I = 1'b1, REQ_VALID_I = 1'b0, PAT_WE_I = 1'b0;
  req_t        REQ_I = '0;
  logic [5:0]  PAT_ADDR_I = 6'h00;
  pat_word_t   PAT_DATA_I = '0;
  logic        PROG_MACHINE_WAIT_IN_I = 1'b0, CHIP_SELECT_MACHINE_ACK_IN_N_I;
  logic        REQ_READY_O, DONE_O, TIMEOUT_O, MEMORY_OUTPUT_ENABLE_N_O, PARITY_BYTE_SELECT_N_O;
  logic [7:0]  CS_N_O, BYTE_WRITE_ENABLE_N_O, SDRAM_BYTE_MASK_O;
  logic [12:0] SDRAM_ADDR_O;
  logic        SDRAM_ROW_COL_LINE_O, SDRAM_WRITE_ENABLE_N_O, SDRAM_ROW_STROBE_N_O;
  logic        SDRAM_COLUMN_STROBE_N_O, SDRAM_ADDR_MUX_CTRL_O;
  logic [5:0]  PROG_MACHINE_GENERAL_LINE_O;
  wire  [5:0]  gpl = PROG_MACHINE_GENERAL_LINE_O;
  logic        ack_en = 1'b1;
  int          fails = 0, checked = 0, a0, a1;

  // Short timeout keeps the no-acknowledge case brief
  memctl_pins #(.ACK_TIMEOUT(16)) uut (.*);
  mem_far_side far (.clk_i(CLK_I), .cs_n_i(CS_N_O), .oe_n_i(MEMORY_OUTPUT_ENABLE_N_O),
    .bwe_n_i(BYTE_WRITE_ENABLE_N_O), .ack_en_i(ack_en), .ack_dly_i(8'h02),
    .ack_n_o(CHIP_SELECT_MACHINE_ACK_IN_N_I));

  initial forever #2.5 CLK_I = ~CLK_I;

  // ----------
  // Helpers
  // ----------
  task automatic tick;
    @(posedge CLK_I);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Pin picked by code: 0 row strobe, 1 column strobe, 2 done
  function automatic logic pin_of(input int which);
    return (which == 0) ? SDRAM_ROW_STROBE_N_O :
           (which == 1) ? SDRAM_COLUMN_STROBE_N_O : DONE_O;
  endfunction

  task automatic wait_is(input int which, input logic v);
    int n = 0;
    while (pin_of(which) !== v && n < 40) begin
      tick;
      n++;
    end
    chk(n < 40, 1'b1, "wait for pin");
  endtask

  task automatic send(input req_t r);
    int n = 0;
    while (REQ_READY_O !== 1'b1 && n < 60) begin
      tick;
      n++;
    end
    REQ_I = r;
    REQ_VALID_I = 1'b1;
    tick;
    REQ_VALID_I = 1'b0;
  endtask

  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic sd_access(input logic wr, ext, ap, input logic [12:0] row, col,
                           input logic [7:0] be);
    send('{mach:MACH_SDRAM, write:wr, auto_pre:ap, parity_en:1'b1, ext_master:ext,
           cs:3'h5, be:be, row:row, col:col, upm_start:6'h00});
    wait_is(0, 1'b0);
    chk(SDRAM_ADDR_O, row, "row address");
    chk(SDRAM_ROW_COL_LINE_O, row[10], "row line");
    chk(SDRAM_ADDR_MUX_CTRL_O, 1'b0, "mux row phase");
    wait_is(1, 1'b0);
    chk(SDRAM_ADDR_O, col & 13'h1bff, "column address");
    chk(SDRAM_ROW_COL_LINE_O, ap, "command line");
    chk(SDRAM_WRITE_ENABLE_N_O, !wr, "write enable");
    chk(SDRAM_BYTE_MASK_O, wr ? 8'(~be) : 8'h00, "byte mask");
    chk(SDRAM_ADDR_MUX_CTRL_O, ext, "mux column phase");
    chk(PARITY_BYTE_SELECT_N_O, 1'b0, "parity select");
    chk(CS_N_O, 8'hdf, "sdram select");
    wait_is(2, 1'b1);
    tick;
    chk({SDRAM_ROW_STROBE_N_O, SDRAM_COLUMN_STROBE_N_O, SDRAM_WRITE_ENABLE_N_O}, 3'h7, "idle");
  endtask

  task automatic gp_access(input logic [2:0] cs, input logic wr, ack);
    int n = 0;
    ack_en = ack;
    send('{mach:MACH_GENERAL_CHIP_SELECT_MACHINE, write:wr, auto_pre:1'b0, parity_en:1'b0, ext_master:1'b0,
           cs:cs, be:8'h3c, row:13'h0000, col:13'h0000, upm_start:6'h00});
    while (CS_N_O === 8'hff && n < 10) begin
      tick;
      n++;
    end
    chk(CS_N_O, 8'(~(8'h01 << cs)), "chip select");
    chk(MEMORY_OUTPUT_ENABLE_N_O, wr, "output enable");
    chk(BYTE_WRITE_ENABLE_N_O, wr ? 8'hc3 : 8'hff, "lane writes");
    n = 0;
    while (DONE_O !== 1'b1 && TIMEOUT_O !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    chk(TIMEOUT_O, !ack, "timeout pulse");
    repeat (2) tick;
    chk(CS_N_O, 8'hff, "select released");
  endtask

  task automatic prog_run(input int stall, output int active);
    logic [5:0] seen[$];
    logic [5:0] last = 6'h3f;
    active = 0;
    send('{mach:MACH_UPM, write:1'b0, auto_pre:1'b0, parity_en:1'b0, ext_master:1'b0,
           cs:3'h1, be:8'h00, row:13'h0000, col:13'h0000, upm_start:6'h04});
    repeat (45) begin
      if (gpl !== 6'h3f) active++;
      if (gpl !== last && gpl !== 6'h3f) seen.push_back(gpl);
      if (active == 1 && stall > 0) PROG_MACHINE_WAIT_IN_I = 1'b1;
      if (active == stall + 1) PROG_MACHINE_WAIT_IN_I = 1'b0;
      last = gpl;
      tick;
    end
    chk(seen.size(), 8, "word count");
    foreach (seen[i]) chk(seen[i], 6'(i + 1), "word value");
  endtask

  // ----------
  // Main sequence
  // ----------
  initial begin
    repeat (20) @(posedge CLK_I);
    #1;
    RST_I = 1'b0;
    tick;
    chk(REQ_READY_O, 1'b1, "ready after reset");
    chk({CS_N_O, SDRAM_BYTE_MASK_O}, 16'hffff, "idle");
    chk({BYTE_WRITE_ENABLE_N_O, 2'b11, gpl}, 16'hffff, "idle lanes");
    $display("reset test done");
    sd_access(1'b1, 1'b1, 1'b1, 13'h0555, 13'h07ff, 8'h5a);
    sd_access(1'b0, 1'b0, 1'b0, 13'h1aaa, 13'h0400, 8'hff);
    $display("sdram test done");
    for (int i = 0; i < 8; i++) gp_access(3'(i), i[0], 1'b1);
    gp_access(3'h2, 1'b0, 1'b0);
    $display("chip select test done");
    for (int i = 0; i < 8; i++) begin
      PAT_WE_I = 1'b1;
      PAT_ADDR_I = 6'(i + 4);
      PAT_DATA_I = '{gpl:6'(i + 1), cs_on:1'b1, bs_on:1'b0, last:(i == 7)};
      tick;
    end
    PAT_WE_I = 1'b0;
    prog_run(0, a0);
    prog_run(12, a1);
    chk(a1 - a0 >= 6, 1'b1, "stall length");
    $display("programmable test done");
    final_report;
  end

  // Runs are a few hundred cycles; this limit only catches a hang
  initial begin
    #100000;
    fails++;
    final_report;
  end
endmodule
